// File: core/sscc_pkg.sv
// Constants, register map and carrier types of the spread clock control
// Assumes a 32-bit AXI4-Lite register bus and one clock domain
package sscc_pkg;

   // Address width of the register bus
   localparam int           AXI_AW          = 10;

   // Register indices; byte address is four times the index
   localparam logic [7:0]   IDX_CONFIG      = 8'h1a;
   localparam logic [7:0]   IDX_SYNC        = 8'h1b;
   localparam logic [7:0]   IDX_LOCK        = 8'h20;
   localparam logic [7:0]   IDX_STATUS      = 8'h21;

   // Reset values
   localparam logic [7:0]   CONFIG_RST      = 8'h00;
   localparam logic [7:0]   SYNC_RST        = 8'h02;
   localparam logic         LOCK_RST        = 1'b0;

   // Bit positions of the lock and status words
   localparam int           LOCK_BIT        = 0;
   localparam int           ST_SPREAD_BIT   = 0;
   localparam int           ST_WAIT_BIT     = 1;
   localparam int           ST_PLL_BIT      = 2;

   // Divider step denominators
   localparam logic [5:0]   STEP_NORMAL     = 6'h1c;
   localparam logic [5:0]   STEP_BOOST      = 6'h38;

   // Spread width in units of 0.3125 percent, full span
   localparam logic [5:0]   WIDTH_5P0       = 6'h10;
   localparam logic [5:0]   WIDTH_2P5       = 6'h08;
   localparam logic [5:0]   WIDTH_1P25      = 6'h04;
   localparam logic [5:0]   WIDTH_0P625     = 6'h02;

   // Highest pixel rate allowed with boost
   localparam int           BOOST_MAX_MHZ   = 25;

   // AXI responses
   localparam logic [1:0]   RESP_OKAY       = 2'h0;
   localparam logic [1:0]   RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      MODE_OUT_ONLY   = 2'b00,
      MODE_ALL_MULT   = 2'b01,
      MODE_OFF        = 2'b10,
      MODE_ALL_NOMULT = 2'b11
   } sscc_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } sscc_state_t;

   typedef struct packed {
      logic [1:0] rate;
      logic       boost;
      logic       gain;
      logic [1:0] width;
      logic       sync_en;
      logic       enable;
   } sscc_config_t;

   typedef struct packed {
      logic       load;
      logic       fifo_rst;
      logic       wave_rst;
      logic       lock_ovr;
      logic       lock_ovr1;
      logic       fastest_modulation;
      sscc_mode_t mode;
   } sscc_sync_t;

endpackage

// File: core/sscc_top.sv
// Spread spectrum clock control: registers, start logic, line sync actions
// Assumes AXI4-Lite master on aclk; line sync and PLL lock arrive unsynchronised
`timescale 1ns/1ps
`default_nettype none

module sscc_top (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address
   input  wire logic [sscc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [sscc_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Pins from outside
   input  wire logic                       line_sync_pulse,
   input  wire logic                       second_pll_lock_raw,
   // Modulator controls
   output logic                            spread_on,
   output logic                            reload_pulse,
   output logic                            fifo_reset,
   output logic                            waveform_reset,
   output logic [2:0]                      rate_mult,
   output logic [5:0]                      div_step,
   output logic [5:0]                      spread_width,
   output sscc_pkg::sscc_mode_t            pll_mode,
   output logic                            fastest_modulation,
   output logic                            second_pll_lock
);
   import sscc_pkg::*;

   // Register index of a byte address
   function automatic logic [7:0] reg_idx(input logic [AXI_AW-1:0] a);
      reg_idx = a[AXI_AW-1:2];
   endfunction

   // Mapped register check
   function automatic logic is_mapped(input logic [7:0] i);
      is_mapped = (i == IDX_CONFIG) || (i == IDX_SYNC) ||
                  (i == IDX_LOCK) || (i == IDX_STATUS);
   endfunction

   sscc_config_t          cfg_reg;
   sscc_sync_t            ctl_reg;
   logic                  lock_reg;
   logic                  en_prev_reg;
   logic                  load_reg;
   sscc_state_t           state_reg;
   sscc_state_t           state_next;

   logic                  aw_have_reg;
   logic                  w_have_reg;
   logic [AXI_AW-1:0]     awaddr_reg;
   logic [7:0]            wdata_reg;
   logic                  wlane_reg;

   logic                  ls_s1_reg;
   logic                  ls_s2_reg;
   logic                  ls_s3_reg;
   logic                  pl_s1_reg;
   logic                  pl_s2_reg;

   logic                  wr_go;
   logic [7:0]            wr_idx;
   logic                  ls_edge;
   logic                  start_ok;
   logic                  reload;
   logic                  start_evt;

   // Synchronisers for the pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ls_s1_reg <= 1'b0;
         ls_s2_reg <= 1'b0;
         ls_s3_reg <= 1'b0;
         pl_s1_reg <= 1'b0;
         pl_s2_reg <= 1'b0;
      end else begin
         ls_s1_reg <= line_sync_pulse;
         ls_s2_reg <= ls_s1_reg;
         ls_s3_reg <= ls_s2_reg;
         pl_s1_reg <= second_pll_lock_raw;
         pl_s2_reg <= pl_s1_reg;
      end
   end

   assign ls_edge = ls_s2_reg & ~ls_s3_reg;

   // Write address and data capture, either order
   assign wr_go  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   assign wr_idx = reg_idx(awaddr_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= 8'h00;
         wlane_reg     <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_have_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata[7:0];
            wlane_reg    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_have_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg  <= CONFIG_RST;
         ctl_reg  <= SYNC_RST;
         lock_reg <= LOCK_RST;
         load_reg <= 1'b0;
      end else begin
         load_reg <= 1'b0;
         if (wr_go && wlane_reg) begin
            if (wr_idx == IDX_CONFIG) begin
               cfg_reg <= wdata_reg;
            end
            if (wr_idx == IDX_SYNC) begin
               ctl_reg      <= {1'b0, wdata_reg[6:0]};
               load_reg     <= wdata_reg[7];
            end
            if (wr_idx == IDX_LOCK) begin
               lock_reg <= wdata_reg[LOCK_BIT];
            end
         end
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         unique case (reg_idx(s_axi_araddr))
            IDX_CONFIG: s_axi_rdata[7:0] <= cfg_reg;
            IDX_SYNC:   s_axi_rdata[7:0] <= ctl_reg;
            IDX_LOCK:   s_axi_rdata[LOCK_BIT] <= lock_reg;
            IDX_STATUS: begin
               s_axi_rdata[ST_SPREAD_BIT] <= spread_on;
               s_axi_rdata[ST_WAIT_BIT]   <= (state_reg == ST_WAIT);
               s_axi_rdata[ST_PLL_BIT]    <= second_pll_lock;
            end
            default:    s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Start conditions and reload requests
   assign start_ok = cfg_reg.enable & lock_reg & (ctl_reg.mode != MODE_OFF);
   assign reload   = load_reg | (cfg_reg.enable & ~en_prev_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_prev_reg <= 1'b0;
      end else begin
         en_prev_reg <= cfg_reg.enable;
      end
   end

   // Spread sequencing
   always_comb begin
      state_next = state_reg;
      start_evt  = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (start_ok && cfg_reg.sync_en) begin
               state_next = ST_WAIT;
            end else if (start_ok) begin
               state_next = ST_RUN;
               start_evt  = 1'b1;
            end
         end
         ST_WAIT: begin
            if (!start_ok) begin
               state_next = ST_IDLE;
            end else if (ls_edge) begin
               state_next = ST_RUN;
               start_evt  = 1'b1;
            end
         end
         ST_RUN: begin
            if (!start_ok) begin
               state_next = ST_IDLE;
            end else if (reload && cfg_reg.sync_en) begin
               state_next = ST_WAIT;
            end else if (reload) begin
               start_evt  = 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Spread level and pulses toward the modulator and FIFO
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spread_on      <= 1'b0;
         reload_pulse   <= 1'b0;
         fifo_reset     <= 1'b0;
         waveform_reset <= 1'b0;
      end else begin
         spread_on      <= (state_next == ST_RUN);
         reload_pulse   <= reload;
         fifo_reset     <= start_evt |
                           (ctl_reg.fifo_rst & ls_edge & (state_reg == ST_RUN));
         waveform_reset <= ctl_reg.wave_rst & ls_edge & (state_reg == ST_RUN);
      end
   end

   // Static settings toward the modulator, and the second PLL lock level, synchronised or forced by the override
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_mult          <= 3'h1;
         div_step           <= STEP_NORMAL;
         spread_width       <= WIDTH_5P0;
         pll_mode           <= MODE_OFF;
         fastest_modulation <= 1'b0;
         second_pll_lock    <= 1'b0;
      end else begin
         unique case (cfg_reg.rate)
            2'b01:   rate_mult <= 3'h2;
            2'b10:   rate_mult <= 3'h4;
            default: rate_mult <= 3'h1;
         endcase
         div_step <= cfg_reg.boost ? STEP_BOOST : STEP_NORMAL;
         unique case (cfg_reg.width)
            2'b00: spread_width <= cfg_reg.gain ? (WIDTH_5P0 << 1) : WIDTH_5P0;
            2'b01: spread_width <= cfg_reg.gain ? (WIDTH_2P5 << 1) : WIDTH_2P5;
            2'b10: spread_width <= cfg_reg.gain ? (WIDTH_1P25 << 1) : WIDTH_1P25;
            2'b11: spread_width <= cfg_reg.gain ? (WIDTH_0P625 << 1) : WIDTH_0P625;
         endcase
         pll_mode           <= ctl_reg.mode;
         fastest_modulation <= ctl_reg.fastest_modulation;
         second_pll_lock    <= ctl_reg.lock_ovr | pl_s2_reg;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wait_armed;
      state_reg == ST_WAIT && start_ok;
   endsequence
   sequence s_sync_seen;
      s_wait_armed ##0 ls_edge;
   endsequence
   a_rate_select: assert property (
      rate_mult == ($past(cfg_reg.rate) == 2'b10 ? 3'h4 :
                    $past(cfg_reg.rate) == 2'b01 ? 3'h2 : 3'h1))
      else $error("rate multiplier wrong");
   a_step_select: assert property (
      $changed(cfg_reg.boost) |=> div_step == (cfg_reg.boost ? STEP_BOOST : STEP_NORMAL))
      else $error("divide step wrong");
   a_gain_double: assert property (
      (cfg_reg.gain && cfg_reg.width == 2'b11) |=> spread_width == 6'h04)
      else $error("gain not doubling width");
   a_unsync_start: assert property (
      (state_reg == ST_IDLE && start_ok && !cfg_reg.sync_en) |=> state_reg == ST_RUN ##0 spread_on)
      else $error("unsynced start missed");
   a_sync_holdoff: assert property (
      s_wait_armed ##0 !ls_edge |=> state_reg != ST_RUN)
      else $error("spread began before line sync");
   a_sync_start: assert property (
      s_sync_seen |=> spread_on && fifo_reset)
      else $error("start at line sync missed");
   a_reload_edge: assert property (
      $rose(cfg_reg.enable) |=> reload_pulse)
      else $error("enable edge did not reload");
   a_load_clear: assert property (
      load_reg |-> !ctl_reg.load ##1 reload_pulse)
      else $error("load bit not self clearing");
   a_wave_reset: assert property (
      (ls_edge && state_reg == ST_RUN && !ctl_reg.wave_rst) |=> !waveform_reset)
      else $error("waveform reset while disabled");
   a_lock_force: assert property (
      ctl_reg.lock_ovr |=> second_pll_lock)
      else $error("lock override ignored");
   a_mode_off: assert property (
      (ctl_reg.mode == MODE_OFF) [*2] |-> !spread_on)
      else $error("spreading while disabled");
   a_fast_mod: assert property (
      $rose(ctl_reg.fastest_modulation) |=> fastest_modulation)
      else $error("fastest modulation not applied");

endmodule

`default_nettype wire

// File: tb/sscc_sync_model.sv
// Host-side model: drives the line sync pin and the raw second PLL lock level
// Assumes the bench requests a sync with a one-cycle fire strobe on aclk
`timescale 1ns/1ps
`default_nettype none

module sscc_sync_model (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Requests from the bench
   input  wire logic fire,
   input  wire logic lock_want,
   // Pins into the block
   output logic      line_sync_pulse,
   output logic      second_pll_lock_raw
);
   logic [2:0] hold_reg;

   // Pulse stays high three cycles, then low at least four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_reg        <= 3'h0;
         line_sync_pulse <= 1'b0;
      end else if (fire && hold_reg == 3'h0) begin
         hold_reg        <= 3'h6;
         line_sync_pulse <= 1'b1;
      end else if (hold_reg != 3'h0) begin
         hold_reg        <= hold_reg - 3'h1;
         line_sync_pulse <= (hold_reg > 3'h4);
      end
   end

   // Lock detector level, one cycle behind the request
   always_ff @(posedge aclk) begin
      second_pll_lock_raw <= aresetn & lock_want;
   end
endmodule
`default_nettype wire

// File: tb/test_spread_spectrum_clock_control.sv
// Self-checking bench for the spread clock control
// Assumes sscc_pkg, sscc_top and the host model sscc_sync_model
`timescale 1ns/1ps
`default_nettype none

module test_spread_spectrum_clock_control;
   import sscc_pkg::*;
   logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, lsp, lock_raw, fire, lock_want;
   logic              spread_on, reload_pulse, fifo_reset, waveform_reset, fastest, pll_lock;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, rd;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, resp;
   logic [2:0]        rate_mult;
   logic [5:0]        div_step, spread_width;
   logic [7:0]        d;
   sscc_mode_t        pll_mode;
   int                fail_count, n_tests, reload_cnt, fifo_cnt, wave_cnt, n, m;

   sscc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_sync_pulse(lsp),
      .second_pll_lock_raw(lock_raw), .spread_on(spread_on), .reload_pulse(reload_pulse),
      .fifo_reset(fifo_reset), .waveform_reset(waveform_reset), .rate_mult(rate_mult),
      .div_step(div_step), .spread_width(spread_width), .pll_mode(pll_mode),
      .fastest_modulation(fastest), .second_pll_lock(pll_lock));

   sscc_sync_model u_host (.aclk(aclk), .aresetn(aresetn), .fire(fire), .lock_want(lock_want),
      .line_sync_pulse(lsp), .second_pll_lock_raw(lock_raw));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Count one-cycle pulses from the block
   always @(posedge aclk) begin
      if (aresetn) begin
         if (reload_pulse === 1'b1) reload_cnt++;
         if (fifo_reset === 1'b1) fifo_cnt++;
         if (waveform_reset === 1'b1) wave_cnt++;
      end
   end

   function automatic logic [2:0] exp_rate(input logic [1:0] c);
      return (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h4 : 3'h1;
   endfunction

   function automatic logic [5:0] exp_width(input logic [1:0] w, input logic g);
      return (6'h10 >> w) << g;
   endfunction

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] r);
      int i;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, v};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 100) begin
         check("write timeout", 1, 0);
         report_and_stop();
      end
   endtask

   task automatic rdt(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            v = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 100) begin
         check("read timeout", 1, 0);
         report_and_stop();
      end
   endtask

   task automatic wok(input logic [7:0] idx, input logic [7:0] v);
      wr(idx, v, resp);
      check("bresp", resp, RESP_OKAY);
      repeat (2) @(posedge aclk);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] v);
      rdt(idx, rd, resp);
      check("rresp", resp, RESP_OKAY);
      check("rdata", rd, {24'h0, v});
   endtask

   task automatic sync_event;
      @(posedge aclk);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (12) @(posedge aclk);
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, lock_want} = 8'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      {fail_count, n_tests, reload_cnt, fifo_cnt, wave_cnt} = '0;
      void'($urandom(32'h5f7e));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check("rate", rate_mult, 3'h1);
      check("step", div_step, 6'h1c);
      check("width", spread_width, 6'h10);
      check("mode", pll_mode, MODE_OFF);
      check("spread", spread_on, 1'b0);
      rdc(IDX_CONFIG, 8'h00);
      rdc(IDX_SYNC, 8'h02);
      // Every rate and width code, random gain and boost
      for (int i = 0; i < 4; i++) begin
         d = (8'($urandom) & 8'h30) | 8'(i << 6) | 8'(i << 2);
         wok(IDX_CONFIG, d);
         check("rate", rate_mult, exp_rate(d[7:6]));
         check("step", div_step, d[5] ? 6'h38 : 6'h1c);
         check("width", spread_width, exp_width(d[3:2], d[4]));
         rdc(IDX_CONFIG, d);
      end
      // Every mode code, both override values, random fastest bit
      for (int i = 0; i < 4; i++) begin
         d = {3'h0, i[0], 1'b0, 1'($urandom), 2'(i)};
         wok(IDX_SYNC, d);
         check("mode", pll_mode, d[1:0]);
         check("fastest", fastest, d[2]);
         check("pll lock", pll_lock, d[4]);
         rdc(IDX_SYNC, d);
      end
      wr(8'h30, 8'hff, resp);
      check("unmapped bresp", resp, RESP_SLVERR);
      rdt(8'h30, rd, resp);
      check("unmapped rresp", resp, RESP_SLVERR);
      check("unmapped rdata", rd, 32'h0);
      // Unsynced start after lock
      wok(IDX_LOCK, 8'h00);
      wok(IDX_SYNC, 8'h11);
      n = reload_cnt;
      wok(IDX_CONFIG, 8'h01);
      check("reload", reload_cnt - n, 1);
      check("spread", spread_on, 1'b0);
      n = fifo_cnt;
      wok(IDX_LOCK, 8'h01);
      check("spread", spread_on, 1'b1);
      check("fifo", fifo_cnt - n, 1);
      n = reload_cnt;
      wok(IDX_SYNC, 8'h91);
      check("load", reload_cnt - n, 1);
      rdc(IDX_SYNC, 8'h11);
      // Line sync with and without its reset actions
      n = fifo_cnt;
      m = wave_cnt;
      sync_event();
      check("fifo", fifo_cnt - n, 0);
      check("wave", wave_cnt - m, 0);
      wok(IDX_SYNC, 8'h71);
      n = fifo_cnt;
      m = wave_cnt;
      sync_event();
      check("fifo", fifo_cnt - n, 1);
      check("wave", wave_cnt - m, 1);
      wok(IDX_CONFIG, 8'h00);
      check("spread", spread_on, 1'b0);
      // Synced start waits for line sync
      wok(IDX_CONFIG, 8'h03);
      repeat (6) @(posedge aclk);
      check("spread", spread_on, 1'b0);
      rdc(IDX_STATUS, 8'h06);
      n = fifo_cnt;
      sync_event();
      check("spread", spread_on, 1'b1);
      check("fifo", fifo_cnt - n, 1);
      rdc(IDX_STATUS, 8'h05);
      rdc(IDX_LOCK, 8'h01);
      // Load while running with line sync goes back to waiting
      wok(IDX_SYNC, 8'hf1);
      check("spread", spread_on, 1'b0);
      rdc(IDX_SYNC, 8'h71);
      sync_event();
      check("spread", spread_on, 1'b1);
      wok(IDX_SYNC, 8'h12);
      check("spread", spread_on, 1'b0);
      check("pll lock", pll_lock, 1'b1);
      wok(IDX_SYNC, 8'h02);
      lock_want <= 1'b1;
      repeat (6) @(posedge aclk);
      check("pll lock", pll_lock, 1'b1);
      lock_want <= 1'b0;
      repeat (6) @(posedge aclk);
      check("pll lock", pll_lock, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
